/* File: dv/remote_station.sv */
// Remote serial station: shifts a 16-bit frame onto the receive pin.
// Assumes one bit lasts eight core_clk cycles and the line idles marking.
`timescale 1ns/1ps
`default_nettype none

module remote_station (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Frame request.
	input  wire logic        load,
	input  wire logic [15:0] frame,
	// Line side.
	output var  logic        rxd_pin,
	output var  logic        rx_bit_tick,
	output var  logic        bit_start,
	output var  logic        last_bit,
	output var  logic        busy
);
	logic [2:0]  cnt;
	logic [15:0] sh;
	logic [4:0]  left;

	assign busy = (left != 5'h00);

	// The tick sits mid-bit so the sampled level is settled.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0;
			sh <= 16'hFFFF;
			left <= 5'h00;
			rxd_pin <= 1'b1;
			rx_bit_tick <= 1'b0;
			bit_start <= 1'b0;
			last_bit <= 1'b1;
		end else begin
			cnt <= cnt + 3'h1;
			rx_bit_tick <= (cnt == 3'h3);
			bit_start <= (cnt == 3'h7);
			if (load) begin
				sh <= frame;
				left <= 5'h10;
			end else if (cnt == 3'h7) begin
				last_bit <= rxd_pin;
				rxd_pin <= busy ? sh[0] : 1'b1;
				sh <= sh >> 1;
				left <= busy ? left - 5'h01 : left;
			end
		end
	end
endmodule

`default_nettype wire

/* File: dv/uart_channel_mode_select_tb.sv */
// Bench for chan_mode_select: APB access and routing in all four modes.
// Assumes remote_station drives the receive pin and the receiver tick.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("wrong value at %0t: got %h expected %h", \
	$time, g, e); end end

module uart_channel_mode_select_tb;
	// Byte addresses are four times the register index.
	localparam logic [7:0] A_TWO = chan_mode_pkg::IDX_SETUP_TWO << 2;
	localparam logic [7:0] A_SEL = chan_mode_pkg::IDX_SELECTOR << 2;
	localparam logic [7:0] A_PTR = chan_mode_pkg::IDX_SELECTOR_PORT << 2;
	logic core_clk = 1'b0, rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rnd, lr;
	logic pready, pslverr, rxd_pin, txd_pin, rx_serial, rx_tick;
	logic tx_serial = 1'b0, tx_bit_tick = 1'b0, host_tx_write = 1'b0;
	logic tx_room_flag, tx_idle_flag, tx_write, rx_bit_tick, queue_push;
	logic parity_err_flag, framing_err_flag, bit_start, last_bit, busy;
	logic load = 1'b0, chk_en = 1'b0, chk_q = 1'b0, exp_tx = 1'b0;
	logic [15:0] frame = 16'hFFFF;
	logic [10:0] exp_v, got_v;
	logic [33:0] ent;
	logic [33:0] exp_q[$];
	chan_mode_pkg::tx_status_t tx_status = '0;
	chan_mode_pkg::rx_event_t rx_event = '0;
	chan_mode_pkg::path_ctrl_t path_ctrl;
	chan_mode_pkg::chan_mode_t tb_mode = chan_mode_pkg::MODE_NORMAL;
	int n_mismatch = 0, num_checks = 0;

	always #5 core_clk = ~core_clk;

	chan_mode_select u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
		.tx_serial(tx_serial), .tx_bit_tick(tx_bit_tick),
		.tx_status(tx_status), .host_tx_write(host_tx_write),
		.tx_room_flag(tx_room_flag), .tx_idle_flag(tx_idle_flag),
		.tx_write(tx_write), .rx_bit_tick(rx_bit_tick),
		.rx_event(rx_event), .rx_serial(rx_serial), .rx_tick(rx_tick),
		.queue_push(queue_push), .parity_err_flag(parity_err_flag),
		.framing_err_flag(framing_err_flag), .path_ctrl(path_ctrl));

	remote_station u_far (.core_clk(core_clk), .rst_n(rst_n),
		.load(load), .frame(frame), .rxd_pin(rxd_pin),
		.rx_bit_tick(rx_bit_tick), .bit_start(bit_start),
		.last_bit(last_bit), .busy(busy));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [10:0] route(chan_mode_pkg::chan_mode_t m);
		logic e;
		logic r;
		e = (m == chan_mode_pkg::MODE_ECHO);
		r = (m == chan_mode_pkg::MODE_REMOTE);
		route = {tx_status.room & ~e, tx_status.idle & ~e,
			host_tx_write & ~e,
			(m == chan_mode_pkg::MODE_LOCAL) ? tx_bit_tick : rx_bit_tick,
			rx_event.char_valid & ~r, rx_event.parity_err & ~r,
			rx_event.framing_err & ~r, ~r, ~r, ~e & ~r, ~e};
	endfunction

	assign got_v = {tx_room_flag, tx_idle_flag, tx_write, rx_tick,
		queue_push, parity_err_flag, framing_err_flag, path_ctrl};

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic [31:0] ed, input logic ee);
		int n;
		exp_q.push_back({wr, ee, ed});
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_sim;
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic set_mode(input logic [1:0] m);
		chk_en <= 1'b0;
		apb(1'b1, A_TWO, {24'h0, m, 6'h15}, 32'h0, 1'b0);
		apb(1'b0, A_TWO, 32'h0, {24'h0, m, 6'h15}, 1'b0);
		tb_mode = chan_mode_pkg::chan_mode_t'(m);
		repeat (16) @(posedge core_clk);
		chk_en <= 1'b1;
	endtask

	task automatic send(input logic [15:0] f);
		int n;
		@(posedge core_clk);
		frame <= f;
		load <= 1'b1;
		@(posedge core_clk);
		load <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (busy !== 1'b0 && n < 200);
		if (busy !== 1'b0) begin
			n_mismatch++;
			end_sim;
		end else begin
			repeat (16) @(posedge core_clk);
		end
	endtask

	always @(posedge core_clk) begin
		if (rst_n) begin
			lr = lfsr(lr);
			tx_serial <= lr[0];
			tx_bit_tick <= lr[3];
			tx_status <= lr[5:4];
			host_tx_write <= lr[6];
			rx_event <= lr[11:7];
		end
	end

	// Outputs are one register behind the inputs seen at the last edge.
	always @(posedge core_clk) begin
		if (chk_q) begin
			`CHK(got_v, exp_v)
			if (tb_mode == chan_mode_pkg::MODE_NORMAL)
				`CHK(txd_pin, exp_tx)
			if (tb_mode == chan_mode_pkg::MODE_LOCAL) begin
				`CHK(txd_pin, 1'b1)
				`CHK(rx_serial, exp_tx)
			end
			if (bit_start && tb_mode[0])
				`CHK(txd_pin, last_bit)
			if (bit_start && tb_mode != chan_mode_pkg::MODE_LOCAL)
				`CHK(rx_serial, last_bit)
		end
		exp_v <= route(tb_mode);
		exp_tx <= tx_serial;
		chk_q <= chk_en;
	end

	always @(posedge core_clk) begin
		if (pready === 1'b1) begin
			ent = exp_q.pop_front();
			`CHK(pslverr, ent[32])
			if (!ent[33])
				`CHK(prdata, ent[31:0])
		end
	end

	initial begin
		rnd = 32'h5e9d;
		lr = 32'h5e9d;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, A_TWO, 32'h0, 32'h0, 1'b0);
		apb(1'b0, A_SEL, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'hFC, 32'hC0, 32'h0, 1'b1);
		apb(1'b0, A_TWO, 32'h0, 32'h0, 1'b0);
		$display("test reset done");
		rnd = lfsr(rnd);
		apb(1'b1, A_TWO, rnd, 32'h0, 1'b0);
		apb(1'b0, A_TWO, 32'h0, {24'h0, rnd[7:0]}, 1'b0);
		apb(1'b1, A_PTR, 32'h3F, 32'h0, 1'b0);
		apb(1'b0, A_PTR, 32'h0, 32'h0, 1'b0);
		apb(1'b0, A_TWO, 32'h0, {24'h0, rnd[7:0]}, 1'b0);
		apb(1'b1, A_SEL, 32'h2, 32'h0, 1'b0);
		apb(1'b0, A_SEL, 32'h0, 32'h2, 1'b0);
		apb(1'b1, A_PTR, 32'h1A, 32'h0, 1'b0);
		apb(1'b0, A_TWO, 32'h0, 32'h1A, 1'b0);
		apb(1'b0, A_PTR, 32'h0, 32'h1A, 1'b0);
		apb(1'b1, A_SEL, 32'h0, 32'h0, 1'b0);
		$display("test pointer done");
		for (int m = 0; m < 4; m++) begin
			set_mode(m[1:0]);
			rnd = lfsr(rnd);
			send({5'h1F, rnd[9:0], 1'b0});
			send(16'h8000);
			$display("test mode %0d done", m);
		end
		end_sim;
	end
endmodule

`default_nettype wire

/* File: shared/chan_mode_pkg.sv */
// Constants and carrier types for the channel mode selection block.
// Assumes a 32-bit APB slave with word-aligned registers on core_clk.
package chan_mode_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_SELECTOR_PORT = 8'h00;
	localparam logic [7:0] IDX_SETUP_TWO     = 8'h22;
	localparam logic [7:0] IDX_SELECTOR      = 8'h01;
	localparam logic [7:0] IDX_STATUS        = 8'h02;
	localparam int         ADDR_LSB          = 2;

	// Field positions of channel_setup_two.
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;

	// Values after reset.
	localparam logic [7:0] SETUP_TWO_RESET = 8'h00;
	localparam logic [1:0] SELECTOR_RESET  = 2'h0;
	// Selector value that steers the pointer port onto channel_setup_two.
	localparam logic [1:0] SELECTOR_SETUP_TWO = 2'h2;

	// Channel modes, in field encoding order.
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ECHO,
		MODE_LOCAL,
		MODE_REMOTE
	} chan_mode_t;

	// Receiver events reported to this block.
	typedef struct packed {
		logic char_valid;
		logic parity_err;
		logic framing_err;
		logic break_det;
		logic start_det;
	} rx_event_t;

	// Transmitter status reported to this block.
	typedef struct packed {
		logic room;
		logic idle;
	} tx_status_t;

	// Path controls handed to receiver and transmitter.
	typedef struct packed {
		logic parity_check_en;
		logic framing_check_en;
		logic parity_regen_en;
		logic tx_host_link_en;
	} path_ctrl_t;

endpackage

/* File: verilog/chan_mode_select.sv */
// Channel mode selection: routes serial data among transmitter, receiver,
// transmit pin and receive pin, and gates status and check enables.
// Assumes bit ticks and receiver/transmitter signals on core_clk; the
// receive pin is asynchronous and is synchronised here.
//
// How it works
// RULE_01: setup register at direct index and pointer.
// RULE_02: bits 7:6 pick normal, echo, local, remote.
// RULE_03: normal mode keeps transmitter and receiver apart.
// RULE_04: echo re-clocks received bits onto transmit pin.
// RULE_05: echo output timed by receiver bit clock.
// RULE_06: host enables receiver for echo and remote.
// RULE_07: echo mode forces tx room, idle inactive.
// RULE_08: echo checks parity, sends received parity unchanged.
// RULE_09: echo checks framing, echoes stops, queues characters.
// RULE_10: break echoed until next valid start bit.
// RULE_11: echo keeps receiver access, cuts host transmit writes.
// RULE_12: local loop feeds transmitter into receiver.
// RULE_13: local loop clocks receiver with transmitter tick.
// RULE_14: local loop holds transmit pin high.
// RULE_15: host enables transmitter for local loopback.
// RULE_16: local loop keeps host access to both normal.
// RULE_17: remote loop re-clocks received bits on receiver tick.
// RULE_18: remote loop delivers nothing, error status inactive.
// RULE_19: remote loop neither checks nor regenerates parity.
// RULE_20: remote loop skips framing, echoes stop bits.
// RULE_21: echoed bit appears within one receiver bit time.
`timescale 1ns/1ps
`default_nettype none

module chan_mode_select #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	// Serial pins.
	input  wire logic                      rxd_pin,
	output var  logic                      txd_pin,
	// Transmitter side.
	input  wire logic                      tx_serial,
	input  wire logic                      tx_bit_tick,
	input  wire chan_mode_pkg::tx_status_t tx_status,
	input  wire logic                      host_tx_write,
	output var  logic                      tx_room_flag,
	output var  logic                      tx_idle_flag,
	output var  logic                      tx_write,
	// Receiver side.
	input  wire logic                      rx_bit_tick,
	input  wire chan_mode_pkg::rx_event_t  rx_event,
	output var  logic                      rx_serial,
	output var  logic                      rx_tick,
	output var  logic                      queue_push,
	output var  logic                      parity_err_flag,
	output var  logic                      framing_err_flag,
	output var  chan_mode_pkg::path_ctrl_t path_ctrl
);

	typedef struct packed {
		logic [7:0]                 setup_two;
		logic [1:0]                 selector;
		logic                       rxd_meta;
		logic                       rxd_sync;
		logic                       echo_bit;
		logic                       break_hold;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic                       txd_pin;
		logic                       tx_room_flag;
		logic                       tx_idle_flag;
		logic                       tx_write;
		logic                       rx_serial;
		logic                       rx_tick;
		logic                       queue_push;
		logic                       parity_err_flag;
		logic                       framing_err_flag;
		chan_mode_pkg::path_ctrl_t  path_ctrl;
	} state_t;

	state_t                   st;
	state_t                   next_st;
	chan_mode_pkg::chan_mode_t mode;
	logic [7:0]               reg_idx;
	logic                     access;
	logic                     hit_direct;
	logic                     hit_pointer;
	logic                     hit_selector;
	logic                     hit_status;

	// Mode comes straight from the stored field.
	assign mode = chan_mode_pkg::chan_mode_t'(
		st.setup_two[chan_mode_pkg::MODE_HI:chan_mode_pkg::MODE_LO]); // [RULE_02]

	assign reg_idx = 8'(paddr >> chan_mode_pkg::ADDR_LSB);
	assign access  = psel && penable && st.pready;
	// Both locations reach the same storage.
	assign hit_direct   = reg_idx == chan_mode_pkg::IDX_SETUP_TWO; // [RULE_01]
	assign hit_pointer  = (reg_idx == chan_mode_pkg::IDX_SELECTOR_PORT) &&
		(st.selector == chan_mode_pkg::SELECTOR_SETUP_TWO); // [RULE_01]
	assign hit_selector = reg_idx == chan_mode_pkg::IDX_SELECTOR;
	assign hit_status   = reg_idx == chan_mode_pkg::IDX_STATUS;

	always_comb begin
		next_st = st;

		// APB: one wait state, so every answer leaves a flip-flop.
		next_st.pready  = psel && penable && !st.pready;
		next_st.pslverr = 1'b0;
		if (psel && penable && !st.pready) begin
			next_st.prdata  = 32'h0000_0000;
			if (hit_direct || hit_pointer) begin
				next_st.prdata[7:0] = st.setup_two;
			end else if (hit_selector) begin
				next_st.prdata[1:0] = st.selector;
			end else if (hit_status) begin
				next_st.prdata[1:0] = mode;
				next_st.prdata[2]   = st.break_hold;
			end else if (reg_idx != chan_mode_pkg::IDX_SELECTOR_PORT) begin
				next_st.pslverr = 1'b1;
			end
		end
		if (access && pwrite) begin
			if (hit_direct || hit_pointer) begin
				next_st.setup_two = pwdata[7:0]; // [RULE_01]
			end else if (hit_selector) begin
				next_st.selector = pwdata[1:0];
			end
		end

		// The pin is foreign to core_clk; second stage feeds all logic.
		next_st.rxd_meta = rxd_pin;
		next_st.rxd_sync = st.rxd_meta;

		// Re-clock the received line on the receiver tick, so the echo
		// lags the line by less than one bit time.
		if (rx_bit_tick) begin
			next_st.echo_bit = st.rxd_sync; // [RULE_04] [RULE_05] [RULE_17] [RULE_21]
		end

		// A break holds until the receiver sees a valid start bit; the
		// echo itself just follows the line, so the low goes out as is.
		if (rx_event.start_det) begin
			next_st.break_hold = 1'b0; // [RULE_10]
		end else if (rx_event.break_det) begin
			next_st.break_hold = 1'b1; // [RULE_10]
		end

		// Defaults are normal operation.
		next_st.txd_pin          = tx_serial; // [RULE_03]
		next_st.rx_serial        = st.rxd_sync; // [RULE_03]
		next_st.rx_tick          = rx_bit_tick;
		next_st.tx_room_flag     = tx_status.room;
		next_st.tx_idle_flag     = tx_status.idle;
		next_st.tx_write         = host_tx_write;
		next_st.queue_push       = rx_event.char_valid; // [RULE_09]
		next_st.parity_err_flag  = rx_event.parity_err;
		next_st.framing_err_flag = rx_event.framing_err; // [RULE_09]
		next_st.path_ctrl        = '{1'b1, 1'b1, 1'b1, 1'b1};

		unique case (mode)
			chan_mode_pkg::MODE_NORMAL: begin
			end
			chan_mode_pkg::MODE_ECHO: begin
				next_st.txd_pin      = st.echo_bit; // [RULE_04] [RULE_10]
				next_st.tx_room_flag = 1'b0; // [RULE_07]
				next_st.tx_idle_flag = 1'b0; // [RULE_07]
				// Receiver still checks and queues; transmitter is cut off.
				next_st.tx_write     = 1'b0; // [RULE_11]
				next_st.path_ctrl.parity_regen_en = 1'b0; // [RULE_08]
				next_st.path_ctrl.tx_host_link_en = 1'b0; // [RULE_11]
			end
			chan_mode_pkg::MODE_LOCAL: begin
				// Host access to both sides is untouched here.
				next_st.txd_pin   = 1'b1; // [RULE_14]
				next_st.rx_serial = tx_serial; // [RULE_12] [RULE_16]
				next_st.rx_tick   = tx_bit_tick; // [RULE_13]
			end
			chan_mode_pkg::MODE_REMOTE: begin
				next_st.txd_pin          = st.echo_bit; // [RULE_17] [RULE_20]
				next_st.queue_push       = 1'b0; // [RULE_18]
				next_st.parity_err_flag  = 1'b0; // [RULE_18]
				next_st.framing_err_flag = 1'b0; // [RULE_18]
				next_st.path_ctrl.parity_check_en  = 1'b0; // [RULE_19]
				next_st.path_ctrl.framing_check_en = 1'b0; // [RULE_20]
				next_st.path_ctrl.parity_regen_en  = 1'b0; // [RULE_19]
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st           <= '0;
			st.setup_two <= chan_mode_pkg::SETUP_TWO_RESET;
			st.selector  <= chan_mode_pkg::SELECTOR_RESET;
			st.rxd_meta  <= 1'b1;
			st.rxd_sync  <= 1'b1;
			st.echo_bit  <= 1'b1;
			st.txd_pin   <= 1'b1;
			st.rx_serial <= 1'b1;
			st.path_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign prdata           = st.prdata;
	assign pready           = st.pready;
	assign pslverr          = st.pslverr;
	assign txd_pin          = st.txd_pin;
	assign tx_room_flag     = st.tx_room_flag;
	assign tx_idle_flag     = st.tx_idle_flag;
	assign tx_write         = st.tx_write;
	assign rx_serial        = st.rx_serial;
	assign rx_tick          = st.rx_tick;
	assign queue_push       = st.queue_push;
	assign parity_err_flag  = st.parity_err_flag;
	assign framing_err_flag = st.framing_err_flag;
	assign path_ctrl        = st.path_ctrl;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_done;
		access && pwrite && (hit_direct || hit_pointer);
	endsequence

	property p_setup_write;
		s_write_done |=> st.setup_two == $past(pwdata[7:0]);
	endproperty
	a_setup_write: assert property (p_setup_write) // [RULE_01]
		else $error("setup register write lost");

	property p_normal_route;
		mode == chan_mode_pkg::MODE_NORMAL |=>
			txd_pin == $past(tx_serial) && rx_tick == $past(rx_bit_tick);
	endproperty
	a_normal_route: assert property (p_normal_route) // [RULE_03]
		else $error("normal mode routing wrong");

	sequence s_echo_tick;
		(mode == chan_mode_pkg::MODE_ECHO ||
		 mode == chan_mode_pkg::MODE_REMOTE) && rx_bit_tick
		##1 (mode == chan_mode_pkg::MODE_ECHO ||
		 mode == chan_mode_pkg::MODE_REMOTE);
	endsequence

	property p_echo_data;
		s_echo_tick |=> txd_pin == $past(st.rxd_sync, 2);
	endproperty
	a_echo_data: assert property (p_echo_data) // [RULE_04]
		else $error("echoed bit differs from received bit");

	property p_echo_hold;
		!rx_bit_tick |=> $stable(st.echo_bit);
	endproperty
	a_echo_hold: assert property (p_echo_hold) // [RULE_05]
		else $error("echo moved without receiver tick");

	property p_echo_status;
		mode == chan_mode_pkg::MODE_ECHO |=>
			!tx_room_flag && !tx_idle_flag && !tx_write;
	endproperty
	a_echo_status: assert property (p_echo_status) // [RULE_07]
		else $error("transmit status or write active in echo");

	property p_echo_checks;
		mode == chan_mode_pkg::MODE_ECHO |=>
			path_ctrl.parity_check_en && path_ctrl.framing_check_en &&
			!path_ctrl.parity_regen_en &&
			queue_push == $past(rx_event.char_valid);
	endproperty
	a_echo_checks: assert property (p_echo_checks) // [RULE_08]
		else $error("echo check enables wrong");

	property p_break_hold;
		st.break_hold && !rx_event.start_det |=> st.break_hold;
	endproperty
	a_break_hold: assert property (p_break_hold) // [RULE_10]
		else $error("break released without start bit");

	property p_local_loop;
		mode == chan_mode_pkg::MODE_LOCAL |=>
			txd_pin && rx_serial == $past(tx_serial) &&
			rx_tick == $past(tx_bit_tick);
	endproperty
	a_local_loop: assert property (p_local_loop) // [RULE_12]
		else $error("local loopback routing wrong");

	property p_remote_quiet;
		mode == chan_mode_pkg::MODE_REMOTE |=>
			!queue_push && !parity_err_flag && !framing_err_flag &&
			!path_ctrl.parity_check_en && !path_ctrl.framing_check_en;
	endproperty
	a_remote_quiet: assert property (p_remote_quiet) // [RULE_18]
		else $error("remote loopback leaks receive data or errors");

	sequence s_access_first;
		psel && penable && !pready;
	endsequence

	property p_one_wait;
		s_access_first |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) // [RULE_01]
		else $error("no answer one cycle after access");

	sequence s_read_setup;
		psel && penable && !pready && !pwrite &&
		(hit_direct || hit_pointer);
	endsequence

	property p_setup_read;
		s_read_setup |=> prdata == {24'h00_0000, $past(st.setup_two)};
	endproperty
	a_setup_read: assert property (p_setup_read) // [RULE_01]
		else $error("setup register read returned wrong word");

	sequence s_unmapped;
		psel && penable && !pready && !hit_direct && !hit_pointer &&
		!hit_selector && !hit_status &&
		reg_idx != chan_mode_pkg::IDX_SELECTOR_PORT;
	endsequence

	property p_unmapped;
		s_unmapped |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) // [RULE_01]
		else $error("unmapped access not refused");

	property p_refused_write;
		s_unmapped ##1 pready |=> $stable(st.setup_two);
	endproperty
	a_refused_write: assert property (p_refused_write) // [RULE_01]
		else $error("refused write changed the setup register");

	property p_echo_frame;
		mode == chan_mode_pkg::MODE_ECHO |=>
			path_ctrl.framing_check_en && !path_ctrl.tx_host_link_en &&
			parity_err_flag == $past(rx_event.parity_err) &&
			framing_err_flag == $past(rx_event.framing_err);
	endproperty
	a_echo_frame: assert property (p_echo_frame) // [RULE_09]
		else $error("echo mode dropped a check or kept host link");

	property p_loop_pin;
		(mode == chan_mode_pkg::MODE_ECHO ||
		 mode == chan_mode_pkg::MODE_REMOTE) |=>
			txd_pin == $past(st.echo_bit);
	endproperty
	a_loop_pin: assert property (p_loop_pin) // [RULE_17]
		else $error("looped pin does not show the echo bit");

	property p_remote_regen;
		mode == chan_mode_pkg::MODE_REMOTE |=>
			!path_ctrl.parity_regen_en && path_ctrl.tx_host_link_en &&
			tx_write == $past(host_tx_write);
	endproperty
	a_remote_regen: assert property (p_remote_regen) // [RULE_19]
		else $error("remote loopback regenerates parity");

	property p_break_clear;
		rx_event.start_det |=> !st.break_hold;
	endproperty
	a_break_clear: assert property (p_break_clear) // [RULE_10]
		else $error("break hold survived a start bit");

	property p_local_host;
		mode == chan_mode_pkg::MODE_LOCAL |=>
			tx_write == $past(host_tx_write) &&
			queue_push == $past(rx_event.char_valid) &&
			path_ctrl == 4'hF;
	endproperty
	a_local_host: assert property (p_local_host) // [RULE_16]
		else $error("local loopback blocks host access");

endmodule

`default_nettype wire
